// ---- core/dcgc_device.sv ----
/*
 device end: parses group command frames, forwards them upward,
 executes writes, relays upper responses and appends its own.
 assumes byte streams from neighbours on this clock, register data
 supplied combinationally on reg_rd_data for reg_rd_addr.
*/
// The register addresses and the address-and-strobe port were decided locally.
`include "dcgc_cfg.svh"
module dcgc_device
  import dcgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  dcgc_link_if.dev         down,
  input  wire logic        up_rsp_valid,
  input  wire logic [7:0]  up_rsp_byte,
  input  wire logic        up_rsp_last,
  input  wire logic        stack_member_flag,
  input  wire logic        chain_top_device,
  input  wire logic [5:0]  dev_addr,
  input  wire logic [7:0]  reg_rd_data,
  output logic             up_cmd_valid,
  output logic      [7:0]  up_cmd_byte,
  output logic             up_cmd_last,
  output logic             reg_wr_en,
  output logic      [15:0] reg_wr_addr,
  output logic      [7:0]  reg_wr_data,
  output logic      [15:0] reg_rd_addr,
  output logic             crc_fault
);
  // ----------------------------------------------------------------
  // command parse
  // ----------------------------------------------------------------
  dcgc_cmd_st_t cst_r;
  logic [7:0]   init_r;
  logic [15:0]  addr_r;
  logic [2:0]   cnt_r;
  logic [7:0]   wbuf_r [0:7];
  logic [7:0]   rcnt_r;
  logic [15:0]  ccrc;
  logic [15:0]  rcrc;
  wire  [2:0]   req     = down.cmd_byte[`DCGC_REQ_HI:`DCGC_REQ_LO];
  wire          is_grp  = down.cmd_byte[`DCGC_FRAME_BIT] &&
                          (req >= `DCGC_REQ_SREAD) && (req <= `DCGC_REQ_BWRITE);
  wire  [2:0]   ireq    = init_r[`DCGC_REQ_HI:`DCGC_REQ_LO];
  wire          is_wr   = (ireq == `DCGC_REQ_SWRITE) || (ireq == `DCGC_REQ_BWRITE);
  wire  [2:0]   nbytes  = is_wr ? init_r[`DCGC_SIZE_HI:`DCGC_SIZE_LO] : 3'h0;
  wire          take    = down.cmd_valid;
  wire          crc_ok  = (ccrc == 16'h0000);
  wire          acts    = (ireq == `DCGC_REQ_BWRITE) || (ireq == `DCGC_REQ_BREAD) ||
                          stack_member_flag;
  wire          go_wr   = is_wr && acts && crc_ok;
  wire          go_rd   = !is_wr && acts && crc_ok;

  dcgc_crc u_ccrc (
    .clock (clock),
    .rstn  (rstn),
    .clear (cst_r == DCGC_IDLE && !take),
    .en    (take),
    .data  (down.cmd_byte),
    .crc   (ccrc)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      up_cmd_valid <= 1'b0;
      up_cmd_byte  <= 8'h00;
      up_cmd_last  <= 1'b0;
    end else begin
      up_cmd_valid <= down.cmd_valid;
      up_cmd_byte  <= down.cmd_byte;
      up_cmd_last  <= down.cmd_last;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cst_r  <= DCGC_IDLE;
      init_r <= 8'h00;
      addr_r <= 16'h0000;
      cnt_r  <= 3'h0;
      rcnt_r <= 8'h00;
    end else if (take) begin
      case (cst_r)
        DCGC_IDLE: begin
          init_r <= down.cmd_byte;
          if (is_grp) cst_r <= DCGC_RADR;
        end
        DCGC_RADR: begin
          addr_r[15:8] <= down.cmd_byte;
          cst_r <= DCGC_RADL;
        end
        DCGC_RADL: begin
          addr_r[7:0] <= down.cmd_byte;
          cnt_r <= 3'h0;
          cst_r <= DCGC_DATA;
        end
        DCGC_DATA: begin
          if (is_wr) wbuf_r[cnt_r] <= down.cmd_byte;
          else rcnt_r <= down.cmd_byte;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == nbytes) cst_r <= DCGC_CRCL;
        end
        DCGC_CRCL: cst_r <= DCGC_CRCH;
        default: cst_r <= DCGC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // write execution
  // ----------------------------------------------------------------
  logic       wact_r;
  logic       fend_r;
  logic [2:0] widx_r;
  logic [2:0] wlast_r;
  wire        frame_end = take && (cst_r == DCGC_CRCH);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wact_r      <= 1'b0;
      fend_r      <= 1'b0;
      widx_r      <= 3'h0;
      wlast_r     <= 3'h0;
      reg_wr_en   <= 1'b0;
      reg_wr_addr <= 16'h0000;
      reg_wr_data <= 8'h00;
    end else begin
      fend_r    <= frame_end;
      reg_wr_en <= wact_r;
      if (wact_r) begin
        reg_wr_addr <= addr_r + {13'h0000, widx_r};
        reg_wr_data <= wbuf_r[widx_r];
        widx_r      <= widx_r + 3'h1;
        if (widx_r == wlast_r) wact_r <= 1'b0;
      end
      if (fend_r && go_wr) begin
        wact_r  <= 1'b1;
        widx_r  <= 3'h0;
        wlast_r <= nbytes;
      end
    end
  end

  // ----------------------------------------------------------------
  // response relay and append
  // ----------------------------------------------------------------
  dcgc_rsp_st_t rst_r;
  logic [7:0]   rlen_r;
  logic [7:0]   ridx_r;
  logic         uchk_r;
  logic [7:0]   sbyte;
  logic [15:0]  scrc;
  wire          up_end = up_rsp_valid && up_rsp_last;
  wire          up_ok  = (rcrc == 16'h0000) || (rst_r != DCGC_RPASS);

  dcgc_crc u_rcrc (
    .clock (clock),
    .rstn  (rstn),
    .clear (!up_rsp_valid && !(rst_r == DCGC_RPASS)),
    .en    (up_rsp_valid),
    .data  (up_rsp_byte),
    .crc   (rcrc)
  );
  dcgc_crc u_scrc (
    .clock (clock),
    .rstn  (rstn),
    .clear (rst_r != DCGC_RSEND),
    .en    (rst_r == DCGC_RSEND && ridx_r < rlen_r - 8'h02),
    .data  (sbyte),
    .crc   (scrc)
  );

  assign reg_rd_addr = addr_r + {8'h00, ridx_r - 8'h04};
  always_comb begin
    sbyte = reg_rd_data;
    if (ridx_r == 8'h00) sbyte = rcnt_r;
    else if (ridx_r == 8'h01) sbyte = {2'b00, dev_addr};
    else if (ridx_r == 8'h02) sbyte = addr_r[15:8];
    else if (ridx_r == 8'h03) sbyte = addr_r[7:0];
    else if (ridx_r == rlen_r - 8'h02) sbyte = scrc[7:0];
    else if (ridx_r == rlen_r - 8'h01) sbyte = scrc[15:8];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_r          <= DCGC_RWAIT;
      rlen_r         <= 8'h00;
      ridx_r         <= 8'h00;
      uchk_r         <= 1'b0;
      crc_fault      <= 1'b0;
      down.rsp_valid <= 1'b0;
      down.rsp_byte  <= 8'h00;
      down.rsp_last  <= 1'b0;
    end else begin
      crc_fault      <= 1'b0;
      down.rsp_valid <= up_rsp_valid;
      down.rsp_byte  <= up_rsp_byte;
      down.rsp_last  <= up_rsp_last;
      case (rst_r)
        DCGC_RWAIT: begin
          if (fend_r && go_rd) begin
            rlen_r <= rcnt_r + 8'h01 + {2'b00, `DCGC_PROTO_BYTES};
            ridx_r <= 8'h00;
            rst_r  <= chain_top_device ? DCGC_RSEND : DCGC_RPASS;
          end
        end
        DCGC_RPASS: begin
          if (uchk_r) begin
            uchk_r <= 1'b0;
            if (up_ok) rst_r <= DCGC_RSEND;
            else begin
              crc_fault <= 1'b1;
              rst_r     <= DCGC_RWAIT;
            end
          end else if (up_end) uchk_r <= 1'b1;
        end
        default: begin
          down.rsp_valid <= 1'b1;
          down.rsp_byte  <= sbyte;
          down.rsp_last  <= (ridx_r == rlen_r - 8'h01);
          ridx_r         <= ridx_r + 8'h01;
          if (ridx_r == rlen_r - 8'h01) rst_r <= DCGC_RWAIT;
        end
      endcase
    end
  end
endmodule

// ---- core/dcgc_cfg.svh ----
/*
 constants for the daisy-chain group command handler: frame codes,
 field positions, sizes. assumes byte-wide frame streams on one clock.
*/
// How it works
// - stack write updates one to eight registers
// - non-member devices skip stack writes
// - write size field is byte count minus one
// - stack read init byte is A0
// - stack write request type 011, B0 upward
// - group frames carry no device address byte
// - read data byte is count minus one
// - host sends read size field zero; host code sends the init byte as software wrote it
// - broadcast read answered by every device
// - top device answers first, then downward
// - hold own answer until upper frame passed
// - bad upper CRC: no append, raise fault
// - response is data plus six protocol bytes
// - response carries own device address
// - broadcast write works without addressing
// - every device executes broadcast write
// - every command frame is forwarded onward
// - host sends start address then data/count
// - broadcast read init byte is C0
// - broadcast write request type 101, D0 upward
// - stack read answered by members only
// - bad command CRC: never execute
`ifndef DCGC_CFG_SVH
`define DCGC_CFG_SVH
`define DCGC_FRAME_BIT    7
`define DCGC_REQ_HI       6
`define DCGC_REQ_LO       4
`define DCGC_SIZE_HI      2
`define DCGC_SIZE_LO      0
`define DCGC_REQ_SREAD    3'h2
`define DCGC_REQ_SWRITE   3'h3
`define DCGC_REQ_BREAD    3'h4
`define DCGC_REQ_BWRITE   3'h5
`define DCGC_INIT_SREAD   8'hA0
`define DCGC_INIT_SWRITE  8'hB0
`define DCGC_INIT_BREAD   8'hC0
`define DCGC_INIT_BWRITE  8'hD0
`define DCGC_PROTO_BYTES  6'h06
`define DCGC_RESP_INIT    8'h00
`define DCGC_CRC_INIT     16'hFFFF
`define DCGC_CRC_POLY     16'hA001
`endif

// ---- core/dcgc_pkg.sv ----
/*
 types for the group command handler.
 assumes dcgc_cfg.svh is included by users of numeric constants.
*/
package dcgc_pkg;
  typedef enum logic [2:0] {
    DCGC_IDLE = 3'h0,
    DCGC_RADR = 3'h1,
    DCGC_RADL = 3'h3,
    DCGC_DATA = 3'h2,
    DCGC_CRCL = 3'h6,
    DCGC_CRCH = 3'h7
  } dcgc_cmd_st_t;
  typedef enum logic [1:0] {
    DCGC_RWAIT = 2'h0,
    DCGC_RPASS = 2'h1,
    DCGC_RSEND = 2'h3
  } dcgc_rsp_st_t;
endpackage

// ---- core/dcgc_link_if.sv ----
/*
 link between chain host and one device: command bytes downward-to-up,
 response bytes back down. assumes one shared clock.
*/
interface dcgc_link_if (
  input wire logic clock
);
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       cmd_last;
  logic       rsp_valid;
  logic [7:0] rsp_byte;
  logic       rsp_last;
  modport host (
    output cmd_valid, cmd_byte, cmd_last,
    input  rsp_valid, rsp_byte, rsp_last
  );
  modport dev (
    input  cmd_valid, cmd_byte, cmd_last,
    output rsp_valid, rsp_byte, rsp_last
  );
endinterface

// ---- core/dcgc_crc.sv ----
/*
 bytewise crc16 (reflected, poly 0x8005) accumulator.
 assumes clear and byte strobes on the same clock.
*/
`include "dcgc_cfg.svh"
module dcgc_crc (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);
  logic [15:0] nxt;
  always_comb begin
    nxt = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      nxt = nxt[0] ? ((nxt >> 1) ^ `DCGC_CRC_POLY) : (nxt >> 1);
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) crc <= `DCGC_CRC_INIT;
    else if (clear) crc <= `DCGC_CRC_INIT;
    else if (en) crc <= nxt;
  end
endmodule

// ---- core/dcgc_host.sv ----
/*
 host end: builds group command frames from software orders and
 collects response bytes. assumes register port on the same clock.
*/
`include "dcgc_cfg.svh"
module dcgc_host
  import dcgc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  dcgc_link_if.host        up,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata
);
  // sw map: 0 cmd/go (init byte), 1 reg addr, 2..5 data bytes pairs,
  // 6 status, 7 last response byte
  logic [7:0]  init_r;
  logic [15:0] radr_r;
  logic [7:0]  dat_r [0:7];
  logic [3:0]  idx_r;
  logic        busy_r;
  logic [7:0]  rsp_r;
  logic [7:0]  rcnt_r;
  logic [7:0]  fbyte;
  logic [15:0] crc;
  wire  [2:0]  req  = init_r[`DCGC_REQ_HI:`DCGC_REQ_LO];
  wire         wr   = (req == `DCGC_REQ_SWRITE) || (req == `DCGC_REQ_BWRITE);
  wire  [2:0]  size = wr ? init_r[`DCGC_SIZE_HI:`DCGC_SIZE_LO] : 3'h0;
  wire  [3:0]  body = 4'h3 + {1'b0, size} + 4'h1;
  wire  [3:0]  len  = body + 4'h1;
  wire  [3:0]  didx = idx_r - 4'h3;

  dcgc_crc u_crc (
    .clock (clock),
    .rstn  (rstn),
    .clear (!busy_r),
    .en    (busy_r && idx_r < body),
    .data  (fbyte),
    .crc   (crc)
  );

  always_comb begin
    fbyte = dat_r[didx[2:0]];
    if (idx_r == 4'h0) fbyte = init_r;
    else if (idx_r == 4'h1) fbyte = radr_r[15:8];
    else if (idx_r == 4'h2) fbyte = radr_r[7:0];
    else if (idx_r == body) fbyte = crc[7:0];
    else if (idx_r == body + 4'h1) fbyte = crc[15:8];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      init_r    <= `DCGC_INIT_BREAD;
      radr_r    <= 16'h0000;
      idx_r     <= 4'h0;
      busy_r    <= 1'b0;
      rsp_r     <= 8'h00;
      rcnt_r    <= 8'h00;
      sw_rdata  <= 16'h0000;
      up.cmd_valid <= 1'b0;
      up.cmd_byte  <= 8'h00;
      up.cmd_last  <= 1'b0;
    end else begin
      up.cmd_valid <= 1'b0;
      up.cmd_last  <= 1'b0;
      if (up.rsp_valid) begin
        rsp_r  <= up.rsp_byte;
        rcnt_r <= rcnt_r + 8'h01;
      end
      if (busy_r) begin
        up.cmd_valid <= 1'b1;
        up.cmd_byte  <= fbyte;
        up.cmd_last  <= (idx_r == len);
        idx_r        <= idx_r + 4'h1;
        if (idx_r == len) busy_r <= 1'b0;
      end else if (sw_wr) begin
        if (sw_addr == 4'h0) begin
          init_r <= sw_wdata[7:0];
          busy_r <= 1'b1;
          idx_r  <= 4'h0;
          rcnt_r <= 8'h00;
        end else if (sw_addr == 4'h1) radr_r <= sw_wdata;
        else if (sw_addr >= 4'h2 && sw_addr <= 4'h5) begin
          dat_r[{sw_addr[1:0] - 2'h2, 1'b0}] <= sw_wdata[7:0];
          dat_r[{sw_addr[1:0] - 2'h2, 1'b1}] <= sw_wdata[15:8];
        end
      end
      if (sw_rd) begin
        if (sw_addr == 4'h6) sw_rdata <= {7'h00, busy_r, rcnt_r};
        else if (sw_addr == 4'h7) sw_rdata <= {8'h00, rsp_r};
        else if (sw_addr == 4'h0) sw_rdata <= {8'h00, init_r};
        else if (sw_addr == 4'h1) sw_rdata <= radr_r;
        else sw_rdata <= 16'h0000;
      end
    end
  end
endmodule

// ---- test/dcgc_asserts.sv ----
/*
 checker for the link between host and device end.
 assumes one clock and rstn, signals taken straight from the link and device.
*/
module dcgc_asserts (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        cmd_last,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_byte,
  input wire logic        rsp_last,
  input wire logic        up_cmd_valid,
  input wire logic [7:0]  up_cmd_byte,
  input wire logic        up_cmd_last,
  input wire logic        up_rsp_valid,
  input wire logic [7:0]  up_rsp_byte,
  input wire logic        reg_wr_en,
  input wire logic [15:0] reg_wr_addr,
  input wire logic        crc_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----
  // response byte counter
  // ----
  logic [8:0] cnt_r;
  logic [7:0] first_r;
  wire  [7:0] head = (cnt_r == 9'h000) ? rsp_byte : first_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 9'h000;
      first_r <= 8'h00;
    end else if (rsp_valid) begin
      cnt_r <= rsp_last ? 9'h000 : cnt_r + 9'h001;
      first_r <= head;
    end
  end
  // ----
  // properties
  // ----
  property p_fwd;
    cmd_valid |=> up_cmd_valid && up_cmd_byte == $past(cmd_byte)
      && up_cmd_last == $past(cmd_last);
  endproperty
  a_fwd: assert property (p_fwd) else $error("command not forwarded");
  property p_init;
    $rose(cmd_valid) |-> cmd_byte[7] && cmd_byte[6:4] inside {[3'h2:3'h5]};
  endproperty
  a_init: assert property (p_init) else $error("bad init byte");
  property p_rd_size;
    $rose(cmd_valid) && !cmd_byte[4] |-> cmd_byte[2:0] == 3'h0;
  endproperty
  a_rd_size: assert property (p_rd_size) else $error("read size not zero");
  property p_wr_incr;
    reg_wr_en && $past(reg_wr_en) |-> reg_wr_addr == $past(reg_wr_addr) + 16'h0001;
  endproperty
  a_wr_incr: assert property (p_wr_incr) else $error("write address skip");
  property p_wr_max;
    reg_wr_en [*8] |=> !reg_wr_en;
  endproperty
  a_wr_max: assert property (p_wr_max) else $error("over eight writes");
  property p_rsp_len;
    rsp_valid && rsp_last |-> cnt_r == {1'b0, head} + 9'h006;
  endproperty
  a_rsp_len: assert property (p_rsp_len) else $error("frame length wrong");
  property p_rsp_contig;
    rsp_valid && !rsp_last |=> rsp_valid;
  endproperty
  a_rsp_contig: assert property (p_rsp_contig) else $error("gap in frame");
  property p_relay;
    up_rsp_valid |=> rsp_valid && rsp_byte == $past(up_rsp_byte);
  endproperty
  a_relay: assert property (p_relay) else $error("upper byte not relayed");
  property p_fault;
    crc_fault |=> !rsp_valid [*4];
  endproperty
  a_fault: assert property (p_fault) else $error("append after fault");
endmodule

// ---- test/tb.sv ----
/*
 bench: host and device joined by one link, upper neighbour played here.
 assumes the design files under core are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic [15:0] sw_rdata;
  logic        member = 1'b0;
  logic        top = 1'b0;
  logic        uv = 1'b0;
  logic [7:0]  ub = 8'h00;
  logic        ul = 1'b0;
  logic        ucv, ucl, wen, fault;
  logic [7:0]  ucb, wdat, rdd;
  logic [15:0] wadr, radr;
  int          fails = 0;
  int          total_checks = 0;
  int          nf = 0;
  logic [7:0]  uq[$], rq[$], eq[$];
  logic [23:0] wq[$];
  always #4 clock = ~clock;
  assign rdd = radr[7:0] ^ 8'h5A;
  dcgc_link_if l (.clock(clock));
  dcgc_host u_dcgc_host (.clock(clock), .rstn(rstn), .up(l.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  dcgc_device u_dcgc_device (.clock(clock), .rstn(rstn), .down(l.dev), .up_rsp_valid(uv),
    .up_rsp_byte(ub), .up_rsp_last(ul), .stack_member_flag(member),
    .chain_top_device(top), .dev_addr(6'h05), .reg_rd_data(rdd), .up_cmd_valid(ucv),
    .up_cmd_byte(ucb), .up_cmd_last(ucl), .reg_wr_en(wen), .reg_wr_addr(wadr),
    .reg_wr_data(wdat), .reg_rd_addr(radr), .crc_fault(fault));
  dcgc_asserts u_dcgc_asserts (.clock(clock), .rstn(rstn), .cmd_valid(l.cmd_valid),
    .cmd_byte(l.cmd_byte), .cmd_last(l.cmd_last), .rsp_valid(l.rsp_valid),
    .rsp_byte(l.rsp_byte), .rsp_last(l.rsp_last), .up_cmd_valid(ucv),
    .up_cmd_byte(ucb), .up_cmd_last(ucl), .up_rsp_valid(uv), .up_rsp_byte(ub),
    .reg_wr_en(wen), .reg_wr_addr(wadr), .crc_fault(fault));
  always @(negedge clock) begin
    if (ucv === 1'b1) uq.push_back(ucb);
    if (l.rsp_valid === 1'b1) rq.push_back(l.rsp_byte);
    if (wen === 1'b1) wq.push_back({wadr, wdat});
    if (fault === 1'b1) nf++;
  end
  // ----
  // tasks
  // ----
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpq(input logic [7:0] g[$], input logic [7:0] e[$]);
    chk(g.size(), e.size());
    foreach (e[i]) if (i < g.size()) chk(g[i], e[i]);
  endtask
  task automatic sw_w(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    @(negedge clock);
    d = sw_rdata;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  function automatic void seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  task automatic cmd(input logic [7:0] init, input logic [15:0] a, input logic [7:0] m,
                     input logic mem, input logic tp);
    logic [7:0] f[$];
    int n;
    int w;
    @(posedge clock);
    member <= mem;
    top <= tp;
    uq.delete();
    rq.delete();
    eq.delete();
    wq.delete();
    n = init[4] ? int'(init[2:0]) + 1 : 1;
    f = '{init, a[15:8], a[7:0]};
    for (int k = 0; k < n; k++) f.push_back(m + k[7:0]);
    seal(f);
    sw_w(4'h1, a);
    for (int k = 0; k < n; k += 2) sw_w(4'h2 + k[4:1], {m + k[7:0] + 8'h01, m + k[7:0]});
    sw_w(4'h0, {8'h00, init});
    w = 0;
    while (w < 99 && ucl !== 1'b1) begin
      @(negedge clock);
      w++;
    end
    if (w == 99) tmo();
    repeat (14) @(negedge clock);
    cmpq(uq, f);
    n = (init[4] && (mem || init[6])) ? n : 0;
    chk(wq.size(), n);
    foreach (wq[k]) chk(wq[k], {a + k[15:0], m + k[7:0]});
  endtask
  task automatic upper(input logic bad);
    logic [7:0] f[$];
    f = '{8'h00, 8'h06, 8'h05, 8'h68, 8'hC3};
    seal(f);
    f[6] = f[6] ^ {7'h00, bad};
    foreach (f[i]) begin
      @(posedge clock);
      uv <= 1'b1;
      ub <= f[i];
      ul <= (i == 6);
    end
    @(posedge clock);
    uv <= 1'b0;
    ul <= 1'b0;
    eq = {eq, f};
  endtask
  task automatic own(input logic [15:0] a, input logic [7:0] m);
    logic [7:0] f[$];
    f = '{m, 8'h05, a[15:8], a[7:0]};
    for (int i = 0; i <= int'(m); i++) f.push_back((a[7:0] + i[7:0]) ^ 8'h5A);
    seal(f);
    eq = {eq, f};
  endtask
  task automatic fin(input string name);
    logic [15:0] v;
    int w;
    w = 0;
    while (w < 400 && rq.size() < eq.size()) begin
      @(negedge clock);
      w++;
    end
    if (w == 400) tmo();
    repeat (20) @(negedge clock);
    cmpq(rq, eq);
    sw_r(4'h6, v);
    chk(v, eq.size());
    if (eq.size() > 0) begin
      sw_r(4'h7, v);
      chk(v[7:0], eq[eq.size() - 1]);
    end
    $display("test %s done", name);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    cmd(8'hB3, 16'h0300, 8'h02, 1'b1, 1'b0);
    fin("stack write four");
    cmd(8'hB7, 16'h0300, 8'h40, 1'b0, 1'b0);
    fin("stack write non member");
    cmd(8'hD7, 16'h10FE, 8'h80, 1'b0, 1'b0);
    fin("broadcast write eight");
    cmd(8'hA0, 16'h0568, 8'h1F, 1'b1, 1'b1);
    own(16'h0568, 8'h1F);
    fin("stack read top");
    cmd(8'hC0, 16'h0568, 8'h03, 1'b0, 1'b0);
    upper(1'b0);
    own(16'h0568, 8'h03);
    fin("broadcast read relay");
    cmd(8'hA0, 16'h0568, 8'h03, 1'b0, 1'b0);
    upper(1'b0);
    fin("stack read non member");
    cmd(8'hC0, 16'h0568, 8'h03, 1'b1, 1'b0);
    upper(1'b1);
    fin("bad upper crc");
    chk(nf, 1);
    summarize();
  end
endmodule
